// ---- common/mss_pkg.sv ----
// Package for the microstep sequencer: register map, field layouts, index and table constants, drive carrier type
`default_nettype none
package mss_pkg;
  // Register byte addresses (word aligned)
  localparam logic [3:0] MSS_ADDR_CTRL = 4'h0;
  localparam logic [3:0] MSS_ADDR_STEP = 4'h4;
  localparam logic [3:0] MSS_ADDR_STATUS = 4'h8;
  localparam logic [3:0] MSS_ADDR_DUTY = 4'hc;
  // Control field positions
  localparam int MSS_CTRL_TORQUE_LSB = 0;
  localparam int MSS_CTRL_FASTDECAY_BIT = 8;
  localparam int MSS_CTRL_HALFSTEP_BIT = 9;
  localparam int MSS_CTRL_RANGE_LSB = 10;
  // Step register fields
  localparam int MSS_STEP_DIR_BIT = 0;
  // Reset values
  localparam logic [7:0] MSS_TORQUE_RST = 8'hff;
  localparam logic [1:0] MSS_RANGE_MAX = 2'h0;
  localparam logic [7:0] MSS_INDEX_RST = 8'h00;
  // Index masks and compare
  localparam logic [7:0] MSS_INDEX_MASK = 8'h1f;
  localparam logic [7:0] MSS_CLK_MASK = 8'h0e;
  localparam logic [7:0] MSS_CLK_MATCH = 8'h08;
  localparam int MSS_QUARTER_STEPS = 16;
  localparam logic [4:0] MSS_QUADRATURE_OFFSET = 5'h10;
  // Done-state cycles before a step request is answered
  localparam logic [1:0] MSS_STEP_CYCLES = 2'h2;

  typedef struct packed {
    logic [3:0] phase;     // A+,A-,B+,B- polarity lines
    logic bridgeADisable;
    logic bridgeBDisable;
    logic seqClock;
    logic seqResetN;
    logic [1:0] rangeSel;
  } mss_drive_t;
endpackage
`default_nettype wire

// ---- logic/mss_sequencer.sv ----
// Microstep sequencer: index, sine lookup, duty words and bridge driver control lines
//
// Chosen here: register access over Avalon-MM and the address map.
`default_nettype none

// Behaviour
// - Byte index increments on forward step, decrements on reverse step.
// - Low five bits of the index address the sine table, wrapping at 32.
// - Sequencer clock goes low at the start of every microstep.
// - Forward: clock rises when five-bit index AND 0x0e equals 8.
// - Reverse: add one before masking, so indexes 7 and 8 raise the clock.
// - Sequencer reset is low out of reset and high after the first step; low for each step that lands the byte index on zero.
// - Phase A duty is table value times torque, upper product byte.
// - Phase B duty uses a table base 90 degrees later, in quadrature.
// - Table holds 16 entries per quarter wave, 16 microsteps per step.
// - Entries: 180 at 45 deg, 254 at peak, 0 at zero crossing.
// - Slow decay: current chopping acts on the normally high phase input.
// - Fast decay: phases driven directly, chopping gates bridge enables.
// - Four phase outputs plus two independent bridge disable outputs.
// - A bridge is disabled whenever its winding wants zero current.
// - Power-on reset keeps the bridges disabled through power up.
// - Current range selects reset to the maximum current setting, then follow the control word.
// - Half-step mode: clock pulses at zero target and first nonzero microstep.
module mss_sequencer
  import mss_pkg::*;
#(
  parameter int TABLE_LEN = 48
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic chopA,
  input wire logic chopB,
  output logic [7:0] phaseADutyWord,
  output logic [7:0] phaseBDutyWord,
  output mss_drive_t drive
);

  // ----------------------------------------------------------------
  // Sine table
  // ----------------------------------------------------------------
  // Three quarter waves from 45 degrees; base A at 0, base B at 16
  function automatic logic [7:0] sineAt(input logic [5:0] pos);
    logic [7:0] v;
    v = 8'h00;
    case (pos)
      6'd0, 6'd16, 6'd32: v = 8'hb4;
      6'd1, 6'd15, 6'd33, 6'd47: v = 8'hc5;
      6'd2, 6'd14, 6'd34, 6'd46: v = 8'hd4;
      6'd3, 6'd13, 6'd35, 6'd45: v = 8'he0;
      6'd4, 6'd12, 6'd36, 6'd44: v = 8'heb;
      6'd5, 6'd11, 6'd37, 6'd43: v = 8'hf4;
      6'd6, 6'd10, 6'd38, 6'd42: v = 8'hfa;
      6'd7, 6'd9, 6'd39, 6'd41: v = 8'hfd;
      6'd8, 6'd40: v = 8'hfe;
      6'd17, 6'd31: v = 8'ha1;
      6'd18, 6'd30: v = 8'h8d;
      6'd19, 6'd29: v = 8'h78;
      6'd20, 6'd28: v = 8'h61;
      6'd21, 6'd27: v = 8'h4a;
      6'd22, 6'd26: v = 8'h31;
      6'd23, 6'd25: v = 8'h18;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Scale by torque keeping the upper product byte
  function automatic logic [7:0] scaleDuty(input logic [7:0] tab, input logic [7:0] torque);
    logic [15:0] prod;
    prod = tab * torque;
    return prod[15:8];
  endfunction

  // Winding polarity over a full electrical cycle of 64 positions
  // The table only holds magnitudes and repeats every 32 positions, so the sign
  // has to come from one more index bit; it flips at each zero entry of that winding
  function automatic logic polarity(input logic [5:0] pos);
    return !pos[5];
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MSS_IDLE = 2'b00,
    MSS_STEP = 2'b01,
    MSS_DONE = 2'b10
  } mss_state_t;

  typedef struct packed {
    mss_state_t fsm;
    logic [1:0] waitCnt;
    logic [7:0] index;
    logic [7:0] torque;
    logic fastDecay;
    logic halfStep;
    logic [1:0] rangeSel;
    logic stepDir;
    logic seqClock;
    logic seqResetN;
    logic zeroA;
    logic zeroB;
    logic polA;
    logic polB;
    logic [7:0] dutyA;
    logic [7:0] dutyB;
    logic [31:0] rdata;
    logic waitReq;
    logic [3:0] phase;
    logic disA;
    logic disB;
    logic clkPend;
    logic [1:0] chopSyncA;
    logic [1:0] chopSyncB;
  } mss_regs_t;

  mss_regs_t state_reg;
  mss_regs_t state_next;

  // Combinational working values
  logic [7:0] newIndex;
  logic [7:0] clkProbe;
  logic [5:0] posA;
  logic [5:0] posB;
  logic [7:0] tabA;
  logic [7:0] tabB;
  logic nzA;
  logic nzB;
  logic busy;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    newIndex = state_reg.index;
    clkProbe = 8'h00;
    posA = 6'h00;
    posB = 6'h00;
    tabA = 8'h00;
    tabB = 8'h00;
    nzA = 1'b0;
    nzB = 1'b0;
    busy = (state_reg.fsm != MSS_IDLE);
    state_next.waitReq = 1'b1;

    // Register writes; a step write starts the microstep sequence
    if (avsWrite && !busy) begin
      case (avsAddress)
        MSS_ADDR_CTRL: begin
          if (avsByteEnable[0]) state_next.torque = avsWriteData[MSS_CTRL_TORQUE_LSB +: 8];
          if (avsByteEnable[1]) begin
            state_next.fastDecay = avsWriteData[MSS_CTRL_FASTDECAY_BIT];
            state_next.halfStep = avsWriteData[MSS_CTRL_HALFSTEP_BIT];
            state_next.rangeSel = avsWriteData[MSS_CTRL_RANGE_LSB +: 2];
          end
        end
        MSS_ADDR_STEP: begin
          if (avsByteEnable[0]) begin
            state_next.stepDir = avsWriteData[MSS_STEP_DIR_BIT];
            state_next.fsm = MSS_STEP;
          end
        end
        default: ;
      endcase
      // Writes other than a step request finish at once
      if (!(avsAddress == MSS_ADDR_STEP && avsByteEnable[0])) begin
        state_next.waitReq = 1'b0;
        state_next.fsm = MSS_DONE;
      end
    end else if (avsRead && !busy) begin
      case (avsAddress)
        MSS_ADDR_CTRL: state_next.rdata = {20'h0, state_reg.rangeSel, state_reg.halfStep,
                                           state_reg.fastDecay, state_reg.torque};
        MSS_ADDR_STEP: state_next.rdata = {31'h0, state_reg.stepDir};
        MSS_ADDR_STATUS: state_next.rdata = {16'h0, state_reg.phase, state_reg.disA,
                                             state_reg.disB, state_reg.seqClock,
                                             state_reg.seqResetN, state_reg.index};
        MSS_ADDR_DUTY: state_next.rdata = {16'h0, state_reg.dutyB, state_reg.dutyA};
        default: state_next.rdata = 32'h0;
      endcase
      state_next.waitReq = 1'b0;
      state_next.fsm = MSS_DONE;
    end

    case (state_reg.fsm)
      MSS_IDLE: ;
      MSS_STEP: begin
        // One microstep: index, clock, reset and both duties in one update
        state_next.seqClock = 1'b0;
        state_next.clkPend = 1'b0;
        state_next.seqResetN = 1'b1;
        if (state_reg.stepDir == 1'b0) begin
          newIndex = state_reg.index + 8'h01;
          clkProbe = newIndex & MSS_INDEX_MASK;
        end else begin
          newIndex = state_reg.index - 8'h01;
          clkProbe = (newIndex & MSS_INDEX_MASK) + 8'h01;
        end
        if (newIndex == 8'h00) state_next.seqResetN = 1'b0;
        posA = {1'b0, newIndex[4:0]};
        posB = {1'b0, newIndex[4:0]} + {1'b0, MSS_QUADRATURE_OFFSET};
        tabA = sineAt(posA);
        tabB = sineAt(posB);
        nzA = (tabA != 8'h00);
        nzB = (tabB != 8'h00);
        if (state_reg.halfStep) begin
          // Pulse on entering zero and again on the first nonzero step
          if ((nzA != !state_reg.zeroA) || (nzB != !state_reg.zeroB)) state_next.clkPend = 1'b1;
        end else if ((clkProbe & MSS_CLK_MASK) == MSS_CLK_MATCH) begin
          state_next.clkPend = 1'b1;
        end
        state_next.index = newIndex;
        state_next.dutyA = scaleDuty(tabA, state_reg.torque);
        state_next.dutyB = scaleDuty(tabB, state_reg.torque);
        state_next.zeroA = !nzA;
        state_next.zeroB = !nzB;
        // Winding A crosses zero at table position 24, winding B a quarter wave earlier
        state_next.polA = polarity(newIndex[5:0] + 6'(MSS_QUARTER_STEPS / 2));
        state_next.polB = polarity(newIndex[5:0] + 6'(MSS_QUARTER_STEPS + MSS_QUARTER_STEPS / 2));
        state_next.waitCnt = MSS_STEP_CYCLES;
        state_next.fsm = MSS_DONE;
      end
      MSS_DONE: begin
        // Clock rises one edge after it was taken low, so two matching steps in a row
        // still give the external sequencer two rising edges
        if (state_reg.waitCnt == MSS_STEP_CYCLES) state_next.seqClock = state_reg.clkPend;
        // Hold waitrequest low for one edge only
        if (state_reg.waitCnt != 2'h0) begin
          state_next.waitCnt = state_reg.waitCnt - 2'h1;
          if (state_reg.waitCnt == 2'h1) state_next.waitReq = 1'b0;
        end else begin
          state_next.fsm = MSS_IDLE;
        end
      end
      default: state_next.fsm = MSS_IDLE;
    endcase

    // Chopping comes from the external current loops, not from this clock:
    // two flops first, and only the second one is read below
    state_next.chopSyncA = {state_reg.chopSyncA[0], chopA};
    state_next.chopSyncB = {state_reg.chopSyncB[0], chopB};

    // Bridge lines; zero current disables the bridge
    state_next.disA = state_reg.zeroA;
    state_next.disB = state_reg.zeroB;
    if (state_reg.fastDecay) begin
      // Phases straight from polarity, chopping gates the enables
      state_next.phase = {state_reg.polA, !state_reg.polA, state_reg.polB, !state_reg.polB};
      state_next.disA = state_reg.zeroA | !state_reg.chopSyncA[1];
      state_next.disB = state_reg.zeroB | !state_reg.chopSyncB[1];
    end else begin
      // Chopping goes onto the phase that is normally high
      state_next.phase = {state_reg.polA & state_reg.chopSyncA[1], !state_reg.polA & state_reg.chopSyncA[1],
                          state_reg.polB & state_reg.chopSyncB[1], !state_reg.polB & state_reg.chopSyncB[1]};
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset leaves both bridges disabled until software steps
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.fsm <= MSS_IDLE;
      state_reg.index <= MSS_INDEX_RST;
      state_reg.torque <= MSS_TORQUE_RST;
      state_reg.rangeSel <= MSS_RANGE_MAX;
      state_reg.seqResetN <= 1'b0;
      state_reg.zeroA <= 1'b1;
      state_reg.zeroB <= 1'b1;
      state_reg.disA <= 1'b1;
      state_reg.disB <= 1'b1;
      state_reg.waitReq <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state flip-flops
  assign avsReadData = state_reg.rdata;
  assign avsWaitRequest = state_reg.waitReq;
  assign phaseADutyWord = state_reg.dutyA;
  assign phaseBDutyWord = state_reg.dutyB;
  assign drive = '{phase: state_reg.phase, bridgeADisable: state_reg.disA,
                   bridgeBDisable: state_reg.disB, seqClock: state_reg.seqClock,
                   seqResetN: state_reg.seqResetN, rangeSel: state_reg.rangeSel};

endmodule
`default_nettype wire

// ---- tb/mss_sequencer_sva.sv ----
// Port checker for the microstep sequencer
`default_nettype none
module mss_sequencer_sva
  import mss_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitRequest,
  input wire logic chopA,
  input wire logic chopB,
  input wire logic [7:0] phaseADutyWord,
  input wire logic [7:0] phaseBDutyWord,
  input wire mss_drive_t drive
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // Bus timing and step side effects
  // ------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic stepReq;
  // Step request as the slave sees it; the master holds it until answered
  assign stepReq = avsWrite && avsAddress == MSS_ADDR_STEP && avsByteEnable[0];
  a_step_answer: assert property ($rose(avsWrite) && stepReq |-> ##4 !avsWaitRequest)
    else $error("step answer not on fourth cycle");
  a_clock_low: assert property ($rose(avsWrite) && stepReq |-> ##2 !drive.seqClock)
    else $error("sequencer clock not low at start of step");
  a_read_answer: assert property ($rose(avsRead) |-> ##1 !avsWaitRequest)
    else $error("read answer not on next cycle");
  a_wait_single: assert property (!avsWaitRequest |=> avsWaitRequest)
    else $error("wait request low longer than one cycle");
  a_clock_cause: assert property ($rose(drive.seqClock) |-> stepReq)
    else $error("sequencer clock rose outside a step");
  a_reset_cause: assert property ($fell(drive.seqResetN) |-> stepReq)
    else $error("sequencer reset pulsed outside a step");
  a_duty_cause: assert property ($changed(phaseADutyWord) || $changed(phaseBDutyWord) |-> avsWrite)
    else $error("duty word changed without a write");
  // Disable lines trail the duty words by one cycle, hence two zero samples
  a_zero_disa: assert property ($past(phaseADutyWord) == 8'h00 && phaseADutyWord == 8'h00 |-> drive.bridgeADisable)
    else $error("bridge A enabled at zero duty");
  a_zero_disb: assert property ($past(phaseBDutyWord) == 8'h00 && phaseBDutyWord == 8'h00 |-> drive.bridgeBDisable)
    else $error("bridge B enabled at zero duty");
  a_range_max: assert property (drive.rangeSel == MSS_RANGE_MAX)
    else $error("current range not at maximum");
  c_clock_rise: cover property ($rose(drive.seqClock));
  c_reset_pulse: cover property ($fell(drive.seqResetN));
  c_bridge_off: cover property ($rose(drive.bridgeADisable));
endmodule

bind mss_sequencer mss_sequencer_sva i_chk (.clk(clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
  .avsWaitRequest(avsWaitRequest), .chopA(chopA), .chopB(chopB), .phaseADutyWord(phaseADutyWord),
  .phaseBDutyWord(phaseBDutyWord), .drive(drive));
`default_nettype wire

// ---- tb/mss_bridge_model.sv ----
// Behavioural bridge driver with peak current chopping
`default_nettype none
module mss_bridge_model
  import mss_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] refA,
  input wire logic [7:0] refB,
  input wire mss_drive_t drive,
  output logic chopA,
  output logic chopB
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rampA;
  logic [7:0] rampB;
  // Sense ramps; short period so the loops toggle often within one step
  // A ramp restarts while its bridge is off, as the winding current has decayed;
  // gating the loop output itself would lock fast-decay enables off for good
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rampA <= 8'h00;
      rampB <= 8'h00;
      chopA <= 1'b0;
      chopB <= 1'b0;
    end else begin
      rampA <= drive.bridgeADisable ? 8'h00 : rampA + 8'h11;
      rampB <= drive.bridgeBDisable ? 8'h00 : rampB + 8'h11;
      chopA <= rampA < refA;
      chopB <= rampB < refB;
    end
  end
endmodule
`default_nettype wire

// ---- tb/test_mss_sequencer.sv ----
// Self-checking bench for the microstep sequencer
`default_nettype none
module test_mss_sequencer
  import mss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // Signals, bus tasks and expectations
  // ------
  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
  logic clk, rst, avsRead, avsWrite, avsWaitRequest, chopA, chopB, fast;
  logic half, zA, zB;
  logic [3:0] avsAddress, avsByteEnable;
  logic [31:0] avsWriteData, avsReadData, rd;
  logic [7:0] phaseADutyWord, phaseBDutyWord, idx, torque;
  mss_drive_t drive;
  int n_errors, comparisons;
  int cyc = 0;
  // Two table rows; the third row repeats the first, so offsets wrap at 32
  localparam logic [255:0] SINE = 256'hb4c5d4e0ebf4fafdfefdfaf4ebe0d4c5b4a18d78614a31180018314a61788da1;
  mss_sequencer i_dut (.clk(clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .chopA(chopA), .chopB(chopB), .phaseADutyWord(phaseADutyWord),
    .phaseBDutyWord(phaseBDutyWord), .drive(drive));
  mss_bridge_model i_bridge (.clk(clk), .rst(rst), .refA(phaseADutyWord), .refB(phaseBDutyWord),
    .drive(drive), .chopA(chopA), .chopB(chopB));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard; a full run needs about 6700 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One bus cycle, held until waitrequest is sampled low; the global guard bounds the wait
  task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do @(posedge clk); while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [7:0] duty(int k);
    logic [15:0] p;
    p = SINE[255 - 8 * (k % 32) -: 8] * torque;
    return p[15:8];
  endfunction
  function automatic logic tz(int k);
    return SINE[255 - 8 * (k % 32) -: 8] == 8'h00;
  endfunction
  // One microstep and its index, clock, reset, duty and disable effects, with phases checked in fast decay only
  task automatic step(input logic rev);
    logic [4:0] i5;
    logic [7:0] t;
    logic [5:0] pa;
    logic [5:0] pb;
    logic ck;
    idx = rev ? idx - 8'h01 : idx + 8'h01;
    i5 = idx[4:0];
    t = rev ? {3'h0, i5} + 8'h01 : {3'h0, i5};
    // Half step pulses on entering or leaving a zero entry in either winding
    ck = half ? (tz(i5) != zA) || (tz(i5 + 16) != zB) : (t & MSS_CLK_MASK) == MSS_CLK_MATCH;
    zA = tz(i5);
    zB = tz(i5 + 16);
    // Winding sign flips at each zero entry, 64 positions per electrical cycle
    pa = idx[5:0] + 6'(MSS_QUARTER_STEPS / 2);
    pb = idx[5:0] + 6'(MSS_QUARTER_STEPS + MSS_QUARTER_STEPS / 2);
    acc(1'b1, MSS_ADDR_STEP, {31'h0, rev});
    acc(1'b0, MSS_ADDR_STATUS, 32'h0);
    `CHK(rd[7:0], idx)
    `CHK(drive.seqClock, ck)
    `CHK(drive.seqResetN, idx != 8'h00)
    if (fast) `CHK(rd[15:12], {!pa[5], pa[5], !pb[5], pb[5]})
    acc(1'b0, MSS_ADDR_DUTY, 32'h0);
    `CHK(rd[15:0], {duty(i5 + 16), duty(i5)})
    `CHK({phaseBDutyWord, phaseADutyWord}, {duty(i5 + 16), duty(i5)})
    // Fast decay may gate the disables with chopping, so only zero is checked there
    if (duty(i5) == 8'h00 || !fast) `CHK(drive.bridgeADisable, duty(i5) == 8'h00)
    if (duty(i5 + 16) == 8'h00 || !fast) `CHK(drive.bridgeBDisable, duty(i5 + 16) == 8'h00)
  endtask
  // ------
  // Test sequence
  // ------
  initial begin
    rst = 1'b1;
    {avsRead, avsWrite, fast, half} = 4'h0;
    {zA, zB} = 2'h3;
    avsAddress = 4'h0;
    avsWriteData = 32'h0;
    avsByteEnable = 4'hf;
    idx = MSS_INDEX_RST;
    torque = MSS_TORQUE_RST;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK({drive.bridgeADisable, drive.bridgeBDisable}, 2'h3)
    `CHK(drive.rangeSel, MSS_RANGE_MAX)
    acc(1'b1, 4'h6, 32'hffffffff);
    acc(1'b0, 4'h6, 32'h0);
    `CHK(rd, 32'h0)
    acc(1'b0, MSS_ADDR_CTRL, 32'h0);
    `CHK(rd[7:0], MSS_TORQUE_RST)
    torque = 8'hc7;
    acc(1'b1, MSS_ADDR_CTRL, {20'h0, MSS_RANGE_MAX, 2'h0, torque});
    repeat (258) step(1'b0);
    torque = 8'h5a;
    fast = 1'b1;
    acc(1'b1, MSS_ADDR_CTRL, {20'h0, MSS_RANGE_MAX, 2'h1, torque});
    repeat (258) step(1'b1);
    {half, fast} = 2'h2;
    acc(1'b1, MSS_ADDR_CTRL, {20'h0, MSS_RANGE_MAX, 2'h2, torque});
    repeat (40) step(1'b0);
    test_done();
  end
endmodule
`default_nettype wire
